// *** verilog/cmtm_top.sv ***
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/10ps
// What this block does
// - extended select bit picks 29-bit matching, else 11-bit standard matching
// - masked incoming id compared with mailbox id; accepted data-frame id copied back
// - bits excluded by the mask packed lowest-first into the family id
// - lowest-numbered available matching receive mailbox stores the data
// - plain receive keeps first message until a new transfer request
// - overwrite mode replaces data each time and flags the overwrite
// - consumer sends remote frame per request and keeps first answer
// - highest programmed priority among ready transmit mailboxes goes first
// - producer sends prepared data when a matching remote frame arrives
// - transmit mailbox reports completion or abort to software
// - 16-bit timer steps once per bus bit while enabled
// - timer clears on reset, sleep, enable change, last mailbox ready rise in time-triggered mode
// - writing the timer clear bit of the command register zeroes timer
// - timer value register reads the live count
// - wrap sets overflow flag, cleared by status read, raises interrupt
// - freeze stops timer at maximum with overflow until a clear
// - timer captured at frame end or start, setting the stamp flag
// - time-triggered mode starts transfer when timer meets mailbox trigger
// - bit time split into sync, propagation and two phase segments
// - eight independently configured mailboxes each with its own id
// - object type field in the mode register selects mailbox behaviour
// - bit time programmable from eight to twenty-five quanta
module cmtm_top
  import cmtm_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  input  wire logic         rx_valid,
  input  wire logic [28:0]  rx_id,
  input  wire logic         rx_ide,
  input  wire logic         rx_rtr,
  input  wire logic [3:0]   rx_dlc,
  input  wire logic [63:0]  rx_data,
  input  wire logic         sof,
  input  wire logic         eof,
  input  wire logic         tx_done,
  input  wire logic         tx_abort,
  output logic              tx_req,
  output logic [28:0]       tx_id,
  output logic              tx_ide,
  output logic              tx_rtr,
  output logic [3:0]        tx_dlc,
  output logic [63:0]       tx_data,
  output logic              bit_tick,
  output logic              irq
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic id_match(input logic [29:0] mid, input logic [29:0] mam,
                                    input logic [28:0] id, input logic ide);
    logic [28:0] m;
    m = mid[`CMTM_ID_EXT] ? mam[28:0] : {mam[28:18], 18'h0_0000};
    return (mid[`CMTM_ID_EXT] == ide) && (((id ^ mid[28:0]) & m) == 29'h0000_0000);
  endfunction : id_match

  function automatic logic [28:0] fam_pack(input logic [28:0] id, input logic [29:0] mam);
    logic [28:0] r;
    logic [4:0]  k;
    r = 29'h0000_0000;
    k = 5'h00;
    for (int b = 0; b < 29; b++) begin
      if ((mam[`CMTM_ID_EXT] || b >= 18) && !mam[b]) begin
        r[k] = id[b];
        k    = k + 5'h01;
      end
    end
    return r;
  endfunction : fam_pack

  function automatic logic [31:0] rd_mux(input cmtm_state_t s, input logic [9:0] a,
                                         input logic bterr);
    logic [31:0] r;
    logic [2:0]  m;
    r = 32'h0000_0000;
    m = a[7:5];
    if (a[`CMTM_MB_SEL]) begin
      case (a[4:0])
        `CMTM_M_MMR:  r = {5'h00, s.object_type_field[m], 4'h0, s.prio[m], s.trig[m]};
        `CMTM_M_MAM:  r = {2'h0, s.mam[m]};
        `CMTM_M_MID:  r = {2'h0, s.mid[m]};
        `CMTM_M_MFID: r = {3'h0, s.mfid[m]};
        `CMTM_M_MSR:  r = {7'h00, s.mmi[m], s.rdy[m], s.abt[m], 2'h0, s.dlc[m], 16'h0000};
        `CMTM_M_MDL:  r = s.data[m][31:0];
        `CMTM_M_MDH:  r = s.data[m][63:32];
        default:      r = 32'h0000_0000;
      endcase
    end else begin
      case (a)
        `CMTM_A_MR:   r = {27'h000_0000, s.time_triggered_select_bit, s.capture_at_frame_end_bit, s.frz, s.low_power_request_bit, s.en};
        `CMTM_A_IMR:  r = {30'h0000_0000, s.imr};
        `CMTM_A_SR:   r = {28'h000_0000, bterr, s.sleep, s.timestamp_flag, s.timer_overflow_flag};
        `CMTM_A_BR:   r = {9'h000, s.brp, 5'h00, s.prop, 1'h0, s.ph1, 1'h0, s.ph2};
        `CMTM_A_TIM:  r = {16'h0000, s.tim};
        `CMTM_A_TIMESTAMP_FLAG: r = {16'h0000, s.stamp};
        default:      r = 32'h0000_0000;
      endcase
    end
    return r;
  endfunction : rd_mux

  // ****************************************************************
  // state
  // ****************************************************************
  cmtm_state_t q;
  cmtm_state_t d;
  logic        dp;
  logic        bterr;
  logic        tim_clr;
  logic        launch;
  logic        store;
  logic [2:0]  best;
  logic [2:0]  hidx;
  logic [3:0]  maxp;
  logic [7:0]  elig;

  assign dp    = q.ap_pend && !q.rdyo;
  // fewer than eight quanta per bit is illegal; the bit clock then stays stopped
  assign bterr = (`CMTM_FIXED_TQ + {2'h0, q.prop} + {2'h0, q.ph1} + {2'h0, q.ph2})
                 < `CMTM_MIN_TQ;

  always_comb begin
    logic       found;
    logic       clr_sw;
    logic       en_edge;
    logic       last_rise;
    logic [2:0] m;
    d         = q;
    found     = 1'b0;
    clr_sw    = 1'b0;
    en_edge   = 1'b0;
    last_rise = 1'b0;
    m         = q.tx_mb;
    best      = 3'h0;
    hidx      = 3'h0;
    maxp      = 4'h0;
    store     = 1'b0;
    launch    = 1'b0;
    d.tick    = 1'b0;

    // ****************************************************************
    // bus slave: one wait state so read data leaves a flop
    // ****************************************************************
    if (hsel && htrans[1] && hready) begin
      d.ap_pend = 1'b1;
      d.ap_wr   = hwrite;
      d.ap_addr = haddr[9:0];
      d.rdyo    = 1'b0;
    end
    if (dp) begin
      d.ap_pend = 1'b0;
      d.rdyo    = 1'b1;
      d.hrdata  = q.ap_wr ? 32'h0000_0000 : rd_mux(q, q.ap_addr, bterr);
      if (!q.ap_wr && q.ap_addr == `CMTM_A_SR) begin
        d.timer_overflow_flag = 1'b0;
        d.timestamp_flag = 1'b0;
      end
      if (q.ap_wr && q.ap_addr[`CMTM_MB_SEL]) begin
        m = q.ap_addr[7:5];
        case (q.ap_addr[4:0])
          `CMTM_M_MMR: begin
            d.trig[m]  = hwdata[15:0];
            d.prio[m]  = hwdata[19:16];
            d.object_type_field[m]   = hwdata[26:24];
            d.armed[m] = 1'b0;
            d.pend[m]  = 1'b0;
          end
          `CMTM_M_MAM: d.mam[m] = hwdata[29:0];
          `CMTM_M_MID: d.mid[m] = hwdata[29:0];
          `CMTM_M_MSR: d.dlc[m] = hwdata[`CMTM_MSR_DLC_LO +: 4];
          `CMTM_M_MDL: d.data[m][31:0] = hwdata;
          `CMTM_M_MDH: d.data[m][63:32] = hwdata;
          default: begin
          end
        endcase
      end else if (q.ap_wr) begin
        case (q.ap_addr)
          `CMTM_A_MR: begin
            d.en   = hwdata[`CMTM_MR_EN];
            d.low_power_request_bit  = hwdata[`CMTM_MR_LPM];
            d.frz  = hwdata[`CMTM_MR_FRZ];
            d.capture_at_frame_end_bit = hwdata[`CMTM_MR_CAPTURE_AT_FRAME_END_BIT];
            d.time_triggered_select_bit  = hwdata[`CMTM_MR_TTM];
          end
          `CMTM_A_IMR: d.imr = hwdata[1:0];
          `CMTM_A_BR: begin
            d.brp  = hwdata[22:16];
            d.prop = hwdata[10:8];
            d.ph1  = hwdata[6:4];
            d.ph2  = hwdata[2:0];
          end
          `CMTM_A_TCR: begin
            clr_sw = hwdata[`CMTM_TCR_TIMCLR];
            for (int i = 0; i < `CMTM_NMB; i++) begin
              if (hwdata[i]) begin
                d.armed[i] = 1'b1;
                d.rdy[i]   = 1'b0;
                d.mmi[i]   = 1'b0;
                d.abt[i]   = 1'b0;
                d.hit[i]   = 1'b0;
                d.rsent[i] = 1'b0;
                d.pend[i]  = 1'b0;
              end
            end
          end
          `CMTM_A_ACR: begin
            // a frame already handed to the engine is left to finish
            for (int i = 0; i < `CMTM_NMB; i++) begin
              if (hwdata[i] && !(q.tx_req && q.tx_mb == 3'(i)) && q.armed[i]) begin
                d.armed[i] = 1'b0;
                d.pend[i]  = 1'b0;
                d.abt[i]   = 1'b1;
                d.rdy[i]   = 1'b1;
              end
            end
          end
          default: begin
          end
        endcase
      end
    end

    // ****************************************************************
    // bit clock: sync, propagation, phase 1, phase 2
    // ****************************************************************
    if (q.en && !bterr && !q.sleep) begin
      if (q.tq_cnt == q.brp) begin
        d.tq_cnt = 7'h00;
        case (q.seg)
          SEG_SYNC: begin
            d.seg     = SEG_PROP;
            d.seg_cnt = 3'h0;
          end
          SEG_PROP: begin
            d.seg     = (q.seg_cnt == q.prop) ? SEG_PH1 : SEG_PROP;
            d.seg_cnt = (q.seg_cnt == q.prop) ? 3'h0 : q.seg_cnt + 3'h1;
          end
          SEG_PH1: begin
            d.seg     = (q.seg_cnt == q.ph1) ? SEG_PH2 : SEG_PH1;
            d.seg_cnt = (q.seg_cnt == q.ph1) ? 3'h0 : q.seg_cnt + 3'h1;
          end
          SEG_PH2: begin
            d.seg     = (q.seg_cnt == q.ph2) ? SEG_SYNC : SEG_PH2;
            d.seg_cnt = (q.seg_cnt == q.ph2) ? 3'h0 : q.seg_cnt + 3'h1;
            d.tick    = (q.seg_cnt == q.ph2);
          end
          default: d.seg = SEG_SYNC;
        endcase
      end else begin
        d.tq_cnt = q.tq_cnt + 7'h01;
      end
    end else begin
      d.tq_cnt  = 7'h00;
      d.seg     = SEG_SYNC;
      d.seg_cnt = 3'h0;
    end

    // ****************************************************************
    // timer
    // ****************************************************************
    d.sleep     = q.low_power_request_bit && !q.tx_req;
    d.en_prev   = q.en;
    d.last_prev = q.rdy[`CMTM_LAST_MB];
    en_edge     = q.en != q.en_prev;
    last_rise   = q.time_triggered_select_bit && q.rdy[`CMTM_LAST_MB] && !q.last_prev;
    tim_clr     = (q.low_power_request_bit && q.sleep) || en_edge || last_rise || clr_sw;
    if (tim_clr) begin
      d.tim = 16'h0000;
    end else if (q.tick && q.en) begin
      if (q.tim == `CMTM_TIM_MAX) begin
        if (!q.frz) begin
          d.tim  = 16'h0000;
          d.timer_overflow_flag = 1'b1;
        end
      end else begin
        d.tim = q.tim + 16'h0001;
        if (q.frz && q.tim == `CMTM_TIM_PRE) begin
          d.timer_overflow_flag = 1'b1;
        end
      end
    end
    if (q.capture_at_frame_end_bit ? eof : sof) begin
      d.stamp = q.tim;
      d.timestamp_flag  = 1'b1;
    end
    for (int i = 0; i < `CMTM_NMB; i++) begin
      if (q.time_triggered_select_bit && q.armed[i] && q.object_type_field[i] == `CMTM_MOT_TX && q.tim == q.trig[i]) begin
        d.hit[i] = 1'b1;
      end
    end

    // ****************************************************************
    // reception: lowest-numbered available match
    // ****************************************************************
    if (rx_valid && q.en && !q.sleep) begin
      for (int i = 0; i < `CMTM_NMB; i++) begin
        if (!found && id_match(q.mid[i], q.mam[i], rx_id, rx_ide)) begin
          if (rx_rtr ? (q.object_type_field[i] == `CMTM_MOT_PROD && q.armed[i] && !q.pend[i])
                     : (((q.object_type_field[i] == `CMTM_MOT_RX) ||
                         (q.object_type_field[i] == `CMTM_MOT_CONS && q.rsent[i])) &&
                        q.armed[i] && !q.rdy[i]) ||
                       (q.object_type_field[i] == `CMTM_MOT_RXOVR && q.armed[i])) begin
            found = 1'b1;
            hidx  = 3'(i);
          end
        end
      end
      if (found && rx_rtr) begin
        d.pend[hidx] = 1'b1;
      end else if (found) begin
        store              = 1'b1;
        d.mid[hidx][28:0]  = rx_id;
        // format bit lives in the id register; mask bit 29 is unused
        d.mfid[hidx]       = fam_pack(rx_id, {q.mid[hidx][`CMTM_ID_EXT],
                                              q.mam[hidx][28:0]});
        d.data[hidx]       = rx_data;
        d.dlc[hidx]        = rx_dlc;
        d.rdy[hidx]        = 1'b1;
        if (q.object_type_field[hidx] == `CMTM_MOT_RXOVR) begin
          d.mmi[hidx] = q.rdy[hidx];
        end else begin
          d.armed[hidx] = 1'b0;
        end
      end
    end

    // ****************************************************************
    // transmission: priority pick, ties to the lowest number
    // ****************************************************************
    for (int i = 0; i < `CMTM_NMB; i++) begin
      elig[i] = (q.object_type_field[i] == `CMTM_MOT_TX && q.armed[i] && (!q.time_triggered_select_bit || q.hit[i])) ||
                (q.object_type_field[i] == `CMTM_MOT_PROD && q.pend[i]) ||
                (q.object_type_field[i] == `CMTM_MOT_CONS && q.armed[i] && !q.rsent[i]);
    end
    for (int i = `CMTM_NMB - 1; i >= 0; i--) begin
      if (elig[i] && q.prio[i] >= maxp) begin
        maxp = q.prio[i];
        best = 3'(i);
      end
    end
    if (q.tx_req) begin
      if (tx_done || tx_abort) begin
        m         = q.tx_mb;
        d.tx_req  = 1'b0;
        d.hit[m]  = 1'b0;
        if (q.object_type_field[m] == `CMTM_MOT_CONS && tx_done) begin
          d.rsent[m] = 1'b1;
        end else begin
          d.armed[m] = 1'b0;
          d.pend[m]  = 1'b0;
          d.rdy[m]   = 1'b1;
          d.abt[m]   = tx_abort;
        end
      end
    end else if (q.en && !q.low_power_request_bit && |elig) begin
      launch    = 1'b1;
      d.tx_req  = 1'b1;
      d.tx_mb   = best;
      d.tx_id   = q.mid[best][28:0];
      d.tx_ide  = q.mid[best][`CMTM_ID_EXT];
      d.tx_rtr  = q.object_type_field[best] == `CMTM_MOT_CONS;
      d.tx_dlc  = q.dlc[best];
      d.tx_data = q.data[best];
    end

    d.irq = (d.timer_overflow_flag && d.imr[0]) || (d.timestamp_flag && d.imr[1]);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q      <= '0;
      q.rdyo <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign hreadyout = q.rdyo;
  assign hresp     = 1'b0;
  assign hrdata    = q.hrdata;
  assign tx_req    = q.tx_req;
  assign tx_id     = q.tx_id;
  assign tx_ide    = q.tx_ide;
  assign tx_rtr    = q.tx_rtr;
  assign tx_dlc    = q.tx_dlc;
  assign tx_data   = q.tx_data;
  assign bit_tick  = q.tick;
  assign irq       = q.irq;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_timer_sw_clear: assert property (@(posedge core_clk) disable iff (!arst_n)
    dp && q.ap_wr && q.ap_addr == `CMTM_A_TCR && hwdata[`CMTM_TCR_TIMCLR] |=> q.tim == 16'h0000)
    else $error("timer not cleared by command");
  a_timer_step: assert property (@(posedge core_clk) disable iff (!arst_n)
    q.tick && q.en && !tim_clr && q.tim != `CMTM_TIM_MAX |=> q.tim == $past(q.tim) + 16'h0001)
    else $error("timer did not advance on bit tick");
  a_timer_idle: assert property (@(posedge core_clk) disable iff (!arst_n)
    !q.tick && !tim_clr |=> $stable(q.tim))
    else $error("timer moved without bit tick");
  a_timer_wrap: assert property (@(posedge core_clk) disable iff (!arst_n)
    q.tick && q.en && !tim_clr && !q.frz && q.tim == `CMTM_TIM_MAX |=> q.tim == 16'h0000 && q.timer_overflow_flag)
    else $error("wrap without overflow flag");
  a_freeze_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
    q.frz && q.tim == `CMTM_TIM_MAX && !tim_clr |=> q.tim == `CMTM_TIM_MAX)
    else $error("frozen timer moved");
  a_stamp_capture: assert property (@(posedge core_clk) disable iff (!arst_n)
    (q.capture_at_frame_end_bit ? eof : sof) |=> q.timestamp_flag && q.stamp == $past(q.tim))
    else $error("timestamp not captured");
  a_status_clear: assert property (@(posedge core_clk) disable iff (!arst_n)
    dp && !q.ap_wr && q.ap_addr == `CMTM_A_SR && !q.tick && !sof && !eof
    |=> !q.timer_overflow_flag && !q.timestamp_flag ##1 q.rdyo)
    else $error("status read did not clear flags");
  a_last_rise_clr: assert property (@(posedge core_clk) disable iff (!arst_n)
    q.time_triggered_select_bit && $rose(q.rdy[`CMTM_LAST_MB]) |=> q.tim == 16'h0000)
    else $error("timer not cleared on last mailbox ready");
  a_tx_priority: assert property (@(posedge core_clk) disable iff (!arst_n)
    launch |=> q.tx_req && q.prio[q.tx_mb] == $past(maxp) && q.tx_id == $past(q.mid[best][28:0]))
    else $error("transmit pick not highest priority");
  a_rx_store: assert property (@(posedge core_clk) disable iff (!arst_n)
    store |=> q.rdy[$past(hidx)] && q.data[$past(hidx)] == $past(rx_data))
    else $error("received data not stored");
  a_rx_lock: assert property (@(posedge core_clk) disable iff (!arst_n)
    q.object_type_field[0] == `CMTM_MOT_RX && q.rdy[0] && !dp |=> q.rdy[0] && $stable(q.data[0]))
    else $error("locked receive mailbox changed");

endmodule : cmtm_top

// *** inc/cmtm_defs.svh ***
`ifndef CMTM_DEFS_SVH
`define CMTM_DEFS_SVH

// ****************************************************************
// sizes
// ****************************************************************
`define CMTM_NMB        8
`define CMTM_LAST_MB    7
`define CMTM_TIM_MAX    16'hFFFF
`define CMTM_TIM_PRE    16'hFFFE
`define CMTM_MIN_TQ     5'h08
`define CMTM_FIXED_TQ   5'h04

// ****************************************************************
// global register byte offsets (haddr[9:0])
// ****************************************************************
`define CMTM_A_MR       10'h000
`define CMTM_A_IMR      10'h004
`define CMTM_A_SR       10'h008
`define CMTM_A_BR       10'h00C
`define CMTM_A_TIM      10'h010
`define CMTM_A_TIMESTAMP_FLAG     10'h014
`define CMTM_A_TCR      10'h018
`define CMTM_A_ACR      10'h01C

// ****************************************************************
// mailbox window: 0x200 + 0x20 * n, offsets within a mailbox
// ****************************************************************
`define CMTM_MB_SEL     9
`define CMTM_M_MMR      5'h00
`define CMTM_M_MAM      5'h04
`define CMTM_M_MID      5'h08
`define CMTM_M_MFID     5'h0C
`define CMTM_M_MSR      5'h10
`define CMTM_M_MDL      5'h14
`define CMTM_M_MDH      5'h18

// ****************************************************************
// field positions
// ****************************************************************
`define CMTM_MR_EN      0
`define CMTM_MR_LPM     1
`define CMTM_MR_FRZ     2
`define CMTM_MR_CAPTURE_AT_FRAME_END_BIT    3
`define CMTM_MR_TTM     4
`define CMTM_TCR_TIMCLR 31
`define CMTM_ID_EXT     29
`define CMTM_MSR_DLC_LO 16

// ****************************************************************
// object type codes
// ****************************************************************
`define CMTM_MOT_OFF    3'h0
`define CMTM_MOT_RX     3'h1
`define CMTM_MOT_RXOVR  3'h2
`define CMTM_MOT_CONS   3'h3
`define CMTM_MOT_TX     3'h4
`define CMTM_MOT_PROD   3'h5

`endif

// *** inc/cmtm_pkg.sv ***
`include "cmtm_defs.svh"

package cmtm_pkg;

  typedef enum logic [1:0] {SEG_SYNC, SEG_PROP, SEG_PH1, SEG_PH2} cmtm_seg_t;

  typedef struct packed {
    logic                ap_pend;
    logic                ap_wr;
    logic [9:0]          ap_addr;
    logic                rdyo;
    logic [31:0]         hrdata;
    logic                en, low_power_request_bit, frz, capture_at_frame_end_bit, time_triggered_select_bit, en_prev, last_prev;
    logic [1:0]          imr;
    logic                timer_overflow_flag, timestamp_flag, sleep;
    logic [6:0]          brp;
    logic [2:0]          prop, ph1, ph2;
    logic [6:0]          tq_cnt;
    cmtm_seg_t           seg;
    logic [2:0]          seg_cnt;
    logic                tick;
    logic [15:0]         tim, stamp;
    logic [7:0][15:0]    trig;
    logic [7:0][3:0]     prio;
    logic [7:0][2:0]     object_type_field;
    logic [7:0][29:0]    mam, mid;
    logic [7:0][28:0]    mfid;
    logic [7:0][3:0]     dlc;
    logic [7:0][63:0]    data;
    logic [7:0]          armed, rdy, mmi, abt, hit, rsent, pend;
    logic                tx_req;
    logic [2:0]          tx_mb;
    logic [28:0]         tx_id;
    logic                tx_ide, tx_rtr;
    logic [3:0]          tx_dlc;
    logic [63:0]         tx_data;
    logic                irq;
  } cmtm_state_t;

endpackage : cmtm_pkg

// *** test/cmtm_node.sv ***
`timescale 1ns/10ps
module cmtm_node (
  input  wire logic        core_clk,
  input  wire logic        tx_req,
  input  wire logic [28:0] tx_id,
  output logic             tx_done,
  output logic             tx_abort,
  output logic             rx_valid,
  output logic             rx_rtr,
  output logic [28:0]      rx_id,
  output logic [63:0]      rx_data,
  output logic             sof,
  output logic             eof
);
  logic [2:0]  wt_q = 3'h0;
  logic [28:0] seen [8];
  int          n = 0;
  initial begin
    {tx_done, tx_abort, rx_valid, rx_rtr, sof, eof} = 6'h00;
    rx_id = 29'h0;
    rx_data = 64'h0;
  end
  // ack once per request after a fixed delay
  always @(posedge core_clk) begin
    tx_done <= tx_req && wt_q == 3'h3;
    if (!tx_req) wt_q <= 3'h0;
    else if (wt_q != 3'h4) wt_q <= wt_q + 3'h1;
    if (tx_req && wt_q == 3'h0) begin
      seen[n] <= tx_id;
      n <= n + 1;
    end
  end
  task automatic send(input logic [28:0] id, input logic [63:0] d, input logic rtr);
    sof <= 1'b1;
    @(posedge core_clk);
    sof <= 1'b0;
    rx_id <= id;
    rx_data <= d;
    rx_valid <= 1'b1;
    rx_rtr <= rtr;
    @(posedge core_clk);
    rx_valid <= 1'b0;
    rx_data <= ~d;
    eof <= 1'b1;
    @(posedge core_clk);
    eof <= 1'b0;
  endtask : send
endmodule : cmtm_node

// *** test/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  logic        core_clk = 0, arst_n = 0, hsel = 1, hwrite = 0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r, b;
  logic        hreadyout, tx_req, tx_done, tx_abort, rx_valid, sof, eof;
  logic        rx_rtr, tx_rtr, hresp, irq, tick;
  logic [28:0] tx_id, rx_id;
  logic [63:0] rx_data, tx_data;
  int          fail_count = 0, num_checks = 0, k;
  always #25 core_clk = ~core_clk;
  cmtm_top u_dut (.core_clk(core_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_valid(rx_valid),
    .rx_id(rx_id), .rx_ide(1'b1), .rx_rtr(rx_rtr), .rx_dlc(4'h8), .rx_data(rx_data),
    .sof(sof), .eof(eof), .tx_done(tx_done), .tx_abort(tx_abort), .tx_req(tx_req),
    .tx_id(tx_id), .tx_ide(), .tx_rtr(tx_rtr), .tx_dlc(), .tx_data(tx_data),
    .bit_tick(tick), .irq(irq));
  cmtm_node u_node (.core_clk(core_clk), .tx_req(tx_req), .tx_id(tx_id), .tx_done(tx_done),
    .tx_abort(tx_abort), .rx_valid(rx_valid), .rx_rtr(rx_rtr), .rx_id(rx_id),
    .rx_data(rx_data), .sof(sof), .eof(eof));
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wait_rdy();
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 40);
    if (k >= 40) begin
      fail_count++;
      test_done();
    end
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask : bus
  task automatic rc(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(r, e);
  endtask : rc
  task automatic wait_tx(input int c);
    for (k = 0; k < 400 && (u_node.n < c || tx_req !== 1'b0); k++) @(posedge core_clk);
    if (k >= 400) begin
      fail_count++;
      test_done();
    end
  endtask : wait_tx
  initial begin
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    rc(32'h0000_0010, 32'h0000_0000);
    rc(32'h0000_0100, 32'h0000_0000);
    bus(1'b1, 32'h0000_000C, 32'h0001_0211);
    bus(1'b1, 32'h0000_0000, 32'h0000_0001);
    for (int m = 0; m < 2; m++) begin
      b = 32'h0000_0200 + 32'(m) * 32'h0000_0020;
      bus(1'b1, b, 32'h0100_0000);
      bus(1'b1, b + 32'h4, 32'h1FFF_FFFC);
      bus(1'b1, b + 32'h8, 32'h2123_4564);
    end
    bus(1'b1, 32'h0000_0018, 32'h0000_0003);
    u_node.send(29'h0123_4566, 64'h1111_1111_1111_1111, 1'b0);
    u_node.send(29'h0123_4567, 64'h2222_2222_2222_2222, 1'b0);
    rc(32'h0000_020C, 32'h0000_0002);
    rc(32'h0000_0208, 32'h2123_4566);
    rc(32'h0000_0214, 32'h1111_1111);
    rc(32'h0000_0234, 32'h2222_2222);
    bus(1'b1, 32'h0000_0004, 32'h0000_0002);
    chk(32'(irq), 32'h0000_0001);
    rc(32'h0000_0008, 32'h0000_0002);
    rc(32'h0000_0008, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    chk(32'(hresp), 32'h0000_0000);
    $display("test rx done");
    // equal priorities on 3 and 4 check the tie order
    for (int m = 2; m < 5; m++) begin
      b = 32'h0000_0200 + 32'(m) * 32'h0000_0020;
      bus(1'b1, b, (m == 2) ? 32'h0401_0000 : 32'h0405_0000);
      bus(1'b1, b + 32'h8, 32'(m));
    end
    bus(1'b1, 32'h0000_0018, 32'h0000_001C);
    wait_tx(3);
    chk(32'(u_node.seen[0]), 32'h0000_0003);
    chk(32'(u_node.seen[1]), 32'h0000_0004);
    chk(32'(u_node.seen[2]), 32'h0000_0002);
    bus(1'b0, 32'h0000_0250, 32'h0);
    chk(32'(r[23]), 32'h0000_0001);
    $display("test tx done");
    // mailbox 5 answers remote frames, mailbox 6 asks for one
    for (int m = 5; m < 7; m++) begin
      b = 32'h0000_0200 + 32'(m) * 32'h0000_0020;
      bus(1'b1, b, (m == 5) ? 32'h0500_0000 : 32'h0300_0000);
      bus(1'b1, b + 32'h4, 32'h1FFF_FFFF);
      bus(1'b1, b + 32'h8, 32'h2000_0050 + 32'(m));
      bus(1'b1, b + 32'h14, 32'h0000_ABC0 + 32'(m));
    end
    bus(1'b1, 32'h0000_0018, 32'h0000_0060);
    wait_tx(4);
    chk(32'(u_node.seen[3]), 32'h0000_0056);
    chk(32'(tx_rtr), 32'h0000_0001);
    u_node.send(29'h0000_0056, 64'h3333_3333_3333_3333, 1'b0);
    rc(32'h0000_02D4, 32'h3333_3333);
    u_node.send(29'h0000_0055, 64'h0000_0000_0000_0000, 1'b1);
    wait_tx(5);
    chk(32'(u_node.seen[4]), 32'h0000_0055);
    chk(tx_data[31:0], 32'h0000_ABC5);
    $display("test remote done");
    // time-triggered: mailbox 7 waits for the timer to reach 2
    bus(1'b1, 32'h0000_0000, 32'h0000_0011);
    bus(1'b1, 32'h0000_02E0, 32'h0400_0002);
    bus(1'b1, 32'h0000_02E8, 32'h0000_0077);
    bus(1'b1, 32'h0000_0018, 32'h8000_0080);
    @(posedge core_clk);
    chk(32'(tx_req), 32'h0000_0000);
    wait_tx(6);
    chk(32'(u_node.seen[5]), 32'h0000_0077);
    bus(1'b0, 32'h0000_0010, 32'h0);
    chk(32'(r < 32'h2), 32'h0000_0001);
    // bit time is (brp+1)*(4+prop+ph1+ph2) = 2*8 clocks
    for (k = 0; k < 40 && tick !== 1'b1; k++) @(posedge core_clk);
    @(posedge core_clk);
    for (k = 1; k < 40 && tick !== 1'b1; k++) @(posedge core_clk);
    chk(k, 32'h0000_0010);
    $display("test trigger done");
    bus(1'b0, 32'h0000_0010, 32'h0);
    chk(32'(r != 32'h0), 32'h0000_0001);
    bus(1'b1, 32'h0000_0018, 32'h8000_0000);
    bus(1'b0, 32'h0000_0010, 32'h0);
    chk(32'(r < 32'h2), 32'h0000_0001);
    $display("test timer done");
    test_done();
  end
endmodule : tb_top
